/* rtl/sbc_top.sv */
// Two-bank SDRAM command, burst and bank control with an APB mode port.
`timescale 1ns/10ps
`include "sbc_cfg.svh"
// Operation
// (RULE1) Activate takes row from address 0-10; bit 11 picks the bank.
// (RULE2) Read/write take column from bits 0-7, bit 10 auto-precharge, bit 11 bank.
// (RULE3) Precharge with bit 10 high closes both banks, ignoring bit 11.
// (RULE4) Read data starts at the given column after CAS latency, then successive columns.
// (RULE5) Drivers turn on CAS latency minus one after read, off after last word.
// (RULE6) In full-page reads the controller ends the burst with burst stop.
// (RULE7) Read byte masks act per byte with two clocks latency.
// (RULE8) Controller activates a bank before reading or writing it.
// (RULE9) First write word is taken on the command edge, later words each clock.
// (RULE10) Write bursts end after burst length; full page needs burst stop.
// (RULE11) Controller waits write recovery after the last write word.
// (RULE12) Write byte masks act per byte on the same clock; masked bytes unwritten.
// (RULE13) Read auto-precharge starts at the burst's final address step.
// (RULE14) Write auto-precharge starts two clocks after the last data word.
// (RULE15) No auto-precharge when burst length is full page.
// (RULE16) A new read replaces the remaining old read burst after CAS latency.
// (RULE17) A new write replaces the remaining old write burst from its clock.
// (RULE18) On read after write the controller frees the data lines in time.
// (RULE19) On write after read the controller masks remaining read output.
// (RULE20) A precharged bank goes idle after the row precharge time.
// (RULE21) Precharge to the reading bank ends output CAS latency clocks later.
// (RULE22) Single-write mode stores one word per write command; reads stay bursts.
// (RULE23) Full-page bursts cover 256 columns and wrap.
// (RULE24) Burst type sets sequential or interleaved column order.
// (RULE25) Commands decode from chip select, row, column strobes and write enable.
module sbc_top #(
  parameter int COL_KEEP = 4,
  parameter int ROW_KEEP = 1
) (
  // Clock, enable and reset.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Memory command pins.
  input wire sbc_pkg::sbc_cmd_s cmd_in,
  // Data pins.
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic [1:0] dq_oe
);
  localparam int AW = 1 + ROW_KEEP + COL_KEEP;
  localparam int MEM_N = 2 ** AW;

  if (COL_KEEP < 1 || COL_KEEP > 8 || ROW_KEEP < 1 || ROW_KEEP > 11) begin : g_chk
    $error("sbc_top: storage size parameters out of range");
  end

  sbc_pkg::sbc_cmd_e cmd_now;
  sbc_pkg::sbc_mode_s mode_q, mode_d;
  sbc_pkg::sbc_eng_s eng_q, eng_d;
  sbc_pkg::sbc_bank_e bank_state [2];
  logic [10:0] bank_row [2];
  logic [1:0] act_b, pre_b, dqm_q, dq_oe_q, dq_oe_d, ap_cnt_q, ap_cnt_d, dqm_in;
  logic [15:0] mem_q [MEM_N];
  logic [15:0] mem_d [MEM_N];
  logic [15:0] rd_word, p1_data_q, p1_data_d, dq_o_q, dq_o_d;
  logic [31:0] prdata_q, prdata_d, mode_word;
  logic [8:0] bl_words;
  logic [7:0] col_in, eng_col;
  logic [AW-1:0] wr_idx;
  logic bank_sel, rd_ok, wr_ok, stop_now, fp, cl3, rd_now, rd_ap_end, ap_fire;
  logic ap_bank_q, ap_bank_d, p1_v_q, p1_v_d, wr_hit, nop_now, pre_rd;
  logic pready_q, pready_d, pslverr_q, pslverr_d, apb_setup, apb_done;

  function automatic logic [AW-1:0] widx(input logic b, input logic [10:0] r,
                                         input logic [7:0] c);
    return {b, r[ROW_KEEP-1:0], c[COL_KEEP-1:0]};
  endfunction

  // Command decode; a deselected device sees no operation.
  always_comb begin
    cmd_now = sbc_pkg::sbc_cmd_e'({cmd_in.ras_n, cmd_in.cas_n, cmd_in.we_n}); // RULE25
    if (cmd_in.cs_n) begin
      cmd_now = sbc_pkg::SBC_CMD_NOP; // RULE25
    end
    nop_now = cmd_now == sbc_pkg::SBC_CMD_NOP;
    bank_sel = cmd_in.addr[`SBC_A_BANK]; // RULE1 RULE2
    col_in = cmd_in.addr[7:0]; // RULE2
    dqm_in = cmd_in.dqm;
  end

  // Mode decode; reserved burst lengths behave as single-word bursts.
  always_comb begin
    fp = mode_q.bl == 3'h7;
    cl3 = mode_q.cl == 3'h3;
    case (mode_q.bl)
      3'h1: bl_words = 9'h2;
      3'h2: bl_words = 9'h4;
      3'h3: bl_words = 9'h8;
      3'h7: bl_words = 9'h100; // RULE23
      default: bl_words = 9'h1;
    endcase
  end

  // Reads and writes to a bank that is not open are ignored.
  always_comb begin
    rd_ok = cmd_now == sbc_pkg::SBC_CMD_RD &&
      bank_state[bank_sel] == sbc_pkg::SBC_BK_ACTIVE; // RULE8
    wr_ok = cmd_now == sbc_pkg::SBC_CMD_WR &&
      bank_state[bank_sel] == sbc_pkg::SBC_BK_ACTIVE; // RULE8
    stop_now = cmd_now == sbc_pkg::SBC_CMD_BST || (cmd_now == sbc_pkg::SBC_CMD_PRE &&
      (cmd_in.addr[`SBC_A_AP] || bank_sel == eng_q.bank)); // RULE21 RULE6
    pre_rd = stop_now && cmd_now == sbc_pkg::SBC_CMD_PRE && eng_q.act && !eng_q.wr;
    ap_fire = ap_cnt_q == 2'h1;
    for (int b = 0; b < 2; b++) begin
      act_b[b] = cmd_now == sbc_pkg::SBC_CMD_ACT && bank_sel == 1'(b); // RULE1
      pre_b[b] = (cmd_now == sbc_pkg::SBC_CMD_PRE &&
        (cmd_in.addr[`SBC_A_AP] || bank_sel == 1'(b))) || // RULE3
        (rd_ap_end && eng_q.bank == 1'(b)) || // RULE13
        (ap_fire && ap_bank_q == 1'(b)); // RULE14
    end
  end

  // Two banks, each with its own precharge timer.
  for (genvar g = 0; g < 2; g++) begin : g_bank
    sbc_bank #(
      .TRP_CYC(`SBC_TRP_CYC)
    ) u_bank (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .act_cmd(act_b[g]),
      .pre_cmd(pre_b[g]),
      .row_in(cmd_in.addr[10:0]),
      .state(bank_state[g]),
      .row(bank_row[g])
    );
  end

  sbc_burst_addr u_addr (
    .start(eng_q.start),
    .idx(eng_q.idx),
    .bl(mode_q.bl),
    .bt(mode_q.bt),
    .col(eng_col)
  );

  // Burst engine; a new read or write simply reloads it, replacing the old burst.
  always_comb begin
    eng_d = eng_q;
    ap_bank_d = ap_bank_q;
    ap_cnt_d = (ap_cnt_q != 2'h0) ? ap_cnt_q - 2'h1 : 2'h0;
    rd_ap_end = 1'b0;
    eng_d.idx = eng_q.idx + 8'h1; // RULE4 RULE9
    if (eng_q.act && !fp) begin
      eng_d.left = eng_q.left - 9'h1;
      if (eng_q.left == 9'h1) begin
        eng_d.act = 1'b0; // RULE5 RULE10
        rd_ap_end = eng_q.ap && !eng_q.wr; // RULE13
        if (eng_q.ap && eng_q.wr) begin
          ap_cnt_d = `SBC_TWR_CYC; // RULE14
          ap_bank_d = eng_q.bank;
        end
      end
    end
    if (stop_now) begin
      eng_d.act = 1'b0; // RULE21
    end
    if (rd_ok || wr_ok) begin
      eng_d.act = rd_ok || (bl_words != 9'h1 && !mode_q.single_wr); // RULE22
      eng_d.wr = wr_ok;
      eng_d.ap = cmd_in.addr[`SBC_A_AP] && !fp; // RULE2 RULE15
      eng_d.bank = bank_sel;
      eng_d.start = col_in; // RULE4
      eng_d.idx = rd_ok ? 8'h0 : 8'h1; // RULE16 RULE17
      eng_d.left = rd_ok ? bl_words : bl_words - 9'h1;
      if (wr_ok && !eng_d.act && eng_d.ap) begin
        ap_cnt_d = `SBC_TWR_CYC; // RULE14
        ap_bank_d = bank_sel;
      end
    end
  end

  // Write port: the command edge takes the first word, the engine the rest.
  always_comb begin
    wr_hit = eng_q.act && eng_q.wr && !stop_now && !rd_ok; // RULE9 RULE10
    wr_idx = widx(eng_q.bank, bank_row[eng_q.bank], eng_col);
    if (wr_ok) begin
      wr_hit = 1'b1; // RULE9
      wr_idx = widx(bank_sel, bank_row[bank_sel], col_in);
    end
    mem_d = mem_q;
    if (wr_hit) begin
      for (int k = 0; k < 2; k++) begin
        if (!dqm_in[k]) begin
          mem_d[wr_idx][k*8 +: 8] = dq_i[k*8 +: 8]; // RULE12
        end
      end
    end
  end

  // Read path: one extra stage at latency three, masks delayed by their own register.
  always_comb begin
    rd_now = eng_q.act && !eng_q.wr;
    rd_word = mem_q[widx(eng_q.bank, bank_row[eng_q.bank], eng_col)]; // RULE4
    p1_v_d = rd_now;
    p1_data_d = rd_word;
    dq_o_d = cl3 ? p1_data_q : rd_word; // RULE4 RULE16
    dq_oe_d = {2{cl3 ? p1_v_q : rd_now}} & ~dqm_q; // RULE5 RULE7
  end

  // APB: one wait state, then the transfer completes; unmapped addresses fail.
  always_comb begin
    apb_setup = psel && penable && !pready_q;
    apb_done = psel && penable && pready_q;
    pready_d = apb_setup;
    mode_word = 32'h0;
    mode_word[`SBC_BL_LSB +: 3] = mode_q.bl;
    mode_word[`SBC_BT_BIT] = mode_q.bt;
    mode_word[`SBC_CL_LSB +: 3] = mode_q.cl;
    mode_word[`SBC_WM_BIT] = mode_q.single_wr;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    if (apb_setup) begin
      case (paddr)
        `SBC_MODE_OFS: prdata_d = mode_word;
        `SBC_STAT_OFS: prdata_d = {25'h0, |dq_oe_q, eng_q.wr, eng_q.act,
          bank_state[1] == sbc_pkg::SBC_BK_PRECH, bank_state[0] == sbc_pkg::SBC_BK_PRECH,
          bank_state[1] == sbc_pkg::SBC_BK_ACTIVE, bank_state[0] == sbc_pkg::SBC_BK_ACTIVE};
        default: begin
          prdata_d = 32'h0;
          pslverr_d = 1'b1;
        end
      endcase
    end
    mode_d = mode_q;
    if (apb_done && pwrite && paddr == `SBC_MODE_OFS) begin
      mode_d.bl = pwdata[`SBC_BL_LSB +: 3];
      mode_d.bt = pwdata[`SBC_BT_BIT];
      mode_d.cl = pwdata[`SBC_CL_LSB +: 3];
      mode_d.single_wr = pwdata[`SBC_WM_BIT];
    end
  end

  // Control registers; the enable freezes everything.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eng_q <= '0;
      ap_cnt_q <= 2'h0;
      ap_bank_q <= 1'b0;
      p1_v_q <= 1'b0;
      p1_data_q <= 16'h0;
      dqm_q <= 2'h0;
      dq_o_q <= 16'h0;
      dq_oe_q <= 2'h0;
      mode_q <= '{bl: `SBC_RST_BL, bt: 1'b0, cl: `SBC_RST_CL, single_wr: 1'b0};
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      eng_q <= eng_d;
      ap_cnt_q <= ap_cnt_d;
      ap_bank_q <= ap_bank_d;
      p1_v_q <= p1_v_d;
      p1_data_q <= p1_data_d;
      dqm_q <= dqm_in; // RULE7
      dq_o_q <= dq_o_d;
      dq_oe_q <= dq_oe_d;
      mode_q <= mode_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Storage holds data only, so it needs no reset.
  always_ff @(posedge pclk) begin
    if (ce) begin
      mem_q <= mem_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign dq_o = dq_o_q;
  assign dq_oe = dq_oe_q;

  // Checks below assume the enable stays high.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn || !ce);

  AST_OE_CL2: assert property ( // RULE5
    rd_ok && !cl3 && dqm_in == 2'h0 |-> ##2 dq_oe == 2'h3)
    else $error("read drivers not on one cycle after read at latency two");
  AST_RMASK_LAT: assert property ( // RULE7
    (dq_oe & $past(dqm_in, 2)) == 2'h0)
    else $error("byte driven although masked two clocks earlier");
  AST_RD_START: assert property ( // RULE4
    rd_ok |=> eng_q.act && !eng_q.wr && eng_col == $past(col_in))
    else $error("read burst does not start at the given column");
  AST_WR_BURST4: assert property ( // RULE10
    wr_ok && mode_q.bl == 3'h2 && !mode_q.single_wr ##1 (nop_now && eng_q.act)[*3]
    |=> !eng_q.act)
    else $error("four-word write burst did not end after its last word");
  AST_SINGLE_WR: assert property ( // RULE22
    wr_ok && mode_q.single_wr |=> !eng_q.act)
    else $error("single-write mode continued a write burst");
  AST_RD_AP: assert property ( // RULE13
    eng_q.act && !eng_q.wr && eng_q.ap && eng_q.left == 9'h1 && !fp && !eng_q.bank
    |=> bank_state[0] == sbc_pkg::SBC_BK_PRECH)
    else $error("read auto-precharge did not start at the last step");
  AST_WR_AP: assert property ( // RULE14
    wr_ok && !bank_sel && cmd_in.addr[`SBC_A_AP] && mode_q.single_wr && !fp
    ##1 nop_now[*2] |-> bank_state[0] == sbc_pkg::SBC_BK_ACTIVE
    ##1 bank_state[0] == sbc_pkg::SBC_BK_PRECH)
    else $error("write auto-precharge not two clocks after last word");
  AST_PRE_BOTH: assert property ( // RULE3
    cmd_now == sbc_pkg::SBC_CMD_PRE && cmd_in.addr[`SBC_A_AP] &&
    bank_state[0] == sbc_pkg::SBC_BK_ACTIVE && bank_state[1] == sbc_pkg::SBC_BK_ACTIVE
    |=> bank_state[0] == sbc_pkg::SBC_BK_PRECH && bank_state[1] == sbc_pkg::SBC_BK_PRECH)
    else $error("precharge of both banks missed one");
  AST_PRE_TERM: assert property ( // RULE21
    pre_rd && !cl3 |-> ##2 dq_oe == 2'h0)
    else $error("read output not ended two clocks after precharge");

  COV_RD: cover property (rd_ok && cl3 ##3 dq_oe == 2'h3);
  COV_WR: cover property (wr_ok ##1 wr_hit);
  COV_RD_AP: cover property (rd_ap_end);
  COV_PRE_TERM: cover property (pre_rd);
endmodule // sbc_top

/* rtl/sbc_cfg.svh */
// Constants for the two-bank SDRAM burst and bank control block.
`ifndef SBC_CFG_SVH
`define SBC_CFG_SVH
// Clock rate and bank timing.
`define SBC_CLK_MHZ 10
`define SBC_TRP_NS 20
`define SBC_TRP_CYC ((`SBC_TRP_NS * `SBC_CLK_MHZ + 999) / 1000)
`define SBC_TWR_CYC 2'h2
`define SBC_RMASK_LAT 2
// Register offsets.
`define SBC_MODE_OFS 8'h00
`define SBC_STAT_OFS 8'h04
// Mode register field positions.
`define SBC_BL_LSB 0
`define SBC_BT_BIT 3
`define SBC_CL_LSB 4
`define SBC_WM_BIT 9
// Mode register reset values.
`define SBC_RST_BL 3'h2
`define SBC_RST_CL 3'h2
// Address pin roles.
`define SBC_A_AP 10
`define SBC_A_BANK 11
`endif

/* rtl/sbc_pkg.sv */
// Types shared by the SDRAM burst and bank control block.
package sbc_pkg;
  typedef enum logic [2:0] {
    SBC_CMD_MRS = 3'h0,
    SBC_CMD_REF = 3'h1,
    SBC_CMD_PRE = 3'h2,
    SBC_CMD_ACT = 3'h3,
    SBC_CMD_WR = 3'h4,
    SBC_CMD_RD = 3'h5,
    SBC_CMD_BST = 3'h6,
    SBC_CMD_NOP = 3'h7
  } sbc_cmd_e;
  typedef enum logic [1:0] {
    SBC_BK_IDLE = 2'h0,
    SBC_BK_ACTIVE = 2'h1,
    SBC_BK_PRECH = 2'h3
  } sbc_bank_e;
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [11:0] addr;
    logic [1:0] dqm;
  } sbc_cmd_s;
  typedef struct packed {
    logic [2:0] bl;
    logic bt;
    logic [2:0] cl;
    logic single_wr;
  } sbc_mode_s;
  typedef struct packed {
    logic act;
    logic wr;
    logic ap;
    logic bank;
    logic [7:0] start;
    logic [7:0] idx;
    logic [8:0] left;
  } sbc_eng_s;
endpackage

/* rtl/sbc_burst_addr.sv */
// Column address generator for one burst step.
`timescale 1ns/10ps
module sbc_burst_addr (
  // Burst start and step number.
  input wire logic [7:0] start,
  input wire logic [7:0] idx,
  // Burst mode.
  input wire logic [2:0] bl,
  input wire logic bt,
  // Generated column.
  output logic [7:0] col
);
  logic [7:0] wrap;

  // Bits that may move within the burst; the rest stay at the start column.
  always_comb begin
    case (bl)
      3'h1: wrap = 8'h01;
      3'h2: wrap = 8'h03;
      3'h3: wrap = 8'h07;
      3'h7: wrap = 8'hff; // RULE23
      default: wrap = 8'h00;
    endcase
  end

  // Interleaved order flips bits, sequential adds; full page is sequential only.
  always_comb begin
    if (bt && bl != 3'h7) begin
      col = (start & ~wrap) | ((start ^ idx) & wrap); // RULE24
    end else begin
      col = (start & ~wrap) | (8'(start + idx) & wrap); // RULE24
    end
  end
endmodule // sbc_burst_addr

/* rtl/sbc_bank.sv */
// State of one bank: idle, active with an open row, or precharging.
`timescale 1ns/10ps
`include "sbc_cfg.svh"
module sbc_bank #(
  parameter int TRP_CYC = `SBC_TRP_CYC
) (
  // Clock, enable and reset.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Bank commands.
  input wire logic act_cmd,
  input wire logic pre_cmd,
  input wire logic [10:0] row_in,
  // Bank state.
  output sbc_pkg::sbc_bank_e state,
  output logic [10:0] row
);
  sbc_pkg::sbc_bank_e state_q, state_d;
  logic [7:0] cnt_q, cnt_d;
  logic [10:0] row_q, row_d;
  logic idle_now;

  if (TRP_CYC < 1 || TRP_CYC > 255) begin : g_chk
    $error("sbc_bank: TRP_CYC out of range");
  end

  // A bank whose precharge time runs out on this edge may be activated at once.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    row_d = row_q;
    idle_now = state_q == sbc_pkg::SBC_BK_IDLE ||
      (state_q == sbc_pkg::SBC_BK_PRECH && cnt_q == 8'h1);
    case (state_q)
      sbc_pkg::SBC_BK_ACTIVE: begin
        if (pre_cmd) begin
          state_d = sbc_pkg::SBC_BK_PRECH; // RULE20
          cnt_d = 8'(TRP_CYC);
        end
      end
      sbc_pkg::SBC_BK_PRECH: begin
        cnt_d = cnt_q - 8'h1;
        if (cnt_q == 8'h1) begin
          state_d = sbc_pkg::SBC_BK_IDLE; // RULE20
        end
      end
      default: state_d = state_q;
    endcase
    if (act_cmd && idle_now) begin
      state_d = sbc_pkg::SBC_BK_ACTIVE;
      row_d = row_in; // RULE1
    end
  end

  // State registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= sbc_pkg::SBC_BK_IDLE;
      cnt_q <= 8'h0;
      row_q <= 11'h0;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      row_q <= row_d;
    end
  end

  assign state = state_q;
  assign row = row_q;
endmodule // sbc_bank

/* test/sbc_ctl_model.sv */
// Memory controller model that drives the command pins and the write data.
`timescale 1ns/10ps
module sbc_ctl_model (
  // Clock.
  input wire logic pclk,
  // Command and data pins.
  output sbc_pkg::sbc_cmd_s cmd_out,
  output logic [15:0] dq_out
);
  logic [15:0] last_q;
  // The bus starts deselected with both byte masks up.
  initial begin
    cmd_out = 18'h3ffff;
    dq_out = 16'h0000;
    last_q = 16'h0000;
  end
  // One selected command with its word; returns at the edge that samples it.
  task automatic step(input logic [2:0] code, input logic [11:0] a, input logic [1:0] m,
                      input logic [15:0] d);
    cmd_out <= {1'b0, code, a, m};
    dq_out <= d;
    last_q <= d;
    @(posedge pclk);
  endtask
  // Deselect; released data lines show the inverse word so stale data never matches.
  task automatic idle(input logic [1:0] m);
    cmd_out <= {1'b1, 3'h7, 12'h000, m};
    dq_out <= ~last_q;
    @(posedge pclk);
  endtask
endmodule // sbc_ctl_model

/* test/test_sdram_burst_bank_control.sv */
// Self-checking bench for the SDRAM burst and bank control block.
`timescale 1ns/10ps
`define CHK(g, e, s) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %0t %s", $time, s); end end
module test_sdram_burst_bank_control;
  localparam logic [2:0] RD = 3'h5, WR = 3'h4, AC = 3'h3, PR = 3'h2, BS = 3'h6, NP = 3'h7;
  typedef struct {logic [11:0] mode; logic [7:0] col; int n; int cl;} sbc_row_s;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] dq_i, dq_o;
  logic [1:0] dq_oe;
  sbc_pkg::sbc_cmd_s cmd_in;
  logic [15:0] exp_mem [16];
  int err_count = 0;
  int n_tests = 0;
  // Read rows: mode word, start column, burst length, CAS latency.
  sbc_row_s rows [7] = '{'{12'h020, 8'h03, 1, 2}, '{12'h021, 8'h05, 2, 2},
    '{12'h022, 8'h02, 4, 2}, '{12'h02a, 8'h09, 4, 2}, '{12'h031, 8'h00, 2, 3},
    '{12'h033, 8'h0d, 8, 3}, '{12'h03b, 8'h06, 8, 3}};

  sbc_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmd_in(cmd_in), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe));
  sbc_ctl_model ctl (.pclk(pclk), .cmd_out(cmd_in), .dq_out(dq_i));

  // Free-running 10 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Prints the verdict and ends the run.
  task automatic give_verdict();
    if (err_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Cuts a hang short; the whole run needs well under a thousand cycles.
  initial begin
    #2000000;
    err_count++;
    give_verdict();
  end

  // One APB transfer; read data lands in rd at the completing edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits for the answer however long it takes; only the watchdog ends a hang.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    `CHK({pready, pslverr}, {1'b1, a > 8'h04}, "apb response")
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Column of burst step i, worked out from the burst order tables.
  function automatic logic [3:0] col_at(logic [7:0] s, int n, logic bt, int i);
    int msk;
    msk = n - 1;
    if (bt) return 4'(int'(s) ^ i);
    return 4'((int'(s) & ~msk) | ((int'(s) + i) & msk));
  endfunction

  // Reads one burst of bank 0 and checks every word as the controller samples it.
  task automatic rd_check(input logic [7:0] c, input int n, input int cl, input logic bt);
    ctl.step(RD, {4'h0, c}, 2'h0, 16'h0000);
    repeat (cl - 1) ctl.idle(2'h0);
    `CHK(dq_oe, 2'h0, "drive too early")
    for (int i = 0; i <= n; i++) begin
      ctl.idle(2'h0);
      if (i < n) `CHK({dq_oe, dq_o}, {2'h3, exp_mem[col_at(c, n, bt, i)]}, "word")
      else `CHK(dq_oe, 2'h0, "no release")
    end
  endtask

  // Main sequence: reset, table of reads, then the awkward cases.
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    `CHK({pready, pslverr, dq_oe}, 4'h0, "reset outputs")
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h0000_0022, "mode reset")
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd, 32'h0, "status reset")
    apb(1'b0, 8'h08, 32'h0);
    `CHK(rd, 32'h0, "unmapped read")
    // Bits outside the mode fields are dropped and read back as zero.
    apb(1'b1, 8'h00, 32'hffff_fde2);
    apb(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h0000_0062, "reserved mode bits")
    apb(1'b1, 8'h00, 32'h0000_0023);
    ctl.step(AC, 12'h000, 2'h0, 16'h0000);
    for (int c = 0; c < 16; c++) begin
      exp_mem[c] = 16'ha000 + 16'(c);
      ctl.step((c % 8 == 0) ? WR : NP, 12'(c) | 12'h300, 2'h0, exp_mem[c]);
    end
    repeat (3) ctl.idle(2'h0);
    foreach (rows[r]) begin
      apb(1'b1, 8'h00, {20'h0, rows[r].mode});
      rd_check(rows[r].col, rows[r].n, rows[r].cl, rows[r].mode[3]);
    end
    // A one-cycle lower byte mask hides exactly one word, two edges later.
    apb(1'b1, 8'h00, 32'h0000_0023);
    ctl.step(RD, 12'h000, 2'h0, 16'h0000);
    ctl.idle(2'h0);
    ctl.idle(2'h1);
    ctl.idle(2'h0);
    `CHK(dq_oe, 2'h3, "mask too early")
    ctl.idle(2'h0);
    `CHK(dq_oe, 2'h2, "lower byte mask")
    ctl.idle(2'h0);
    `CHK(dq_oe, 2'h3, "mask release")
    repeat (6) ctl.idle(2'h0);
    // Masked first word, write interrupted after one clock, then a single write.
    apb(1'b1, 8'h00, 32'h0000_0022);
    ctl.step(WR, 12'h000, 2'h2, 16'h1111);
    ctl.step(WR, 12'h00c, 2'h0, 16'h2222);
    for (int c = 3; c < 6; c++) ctl.step(NP, 12'h000, 2'h0, 16'h1111 * 16'(c));
    repeat (3) ctl.idle(2'h0);
    apb(1'b1, 8'h00, 32'h0000_0222);
    ctl.step(WR, 12'h004, 2'h0, 16'h6666);
    ctl.step(NP, 12'h000, 2'h0, 16'h7777);
    repeat (3) ctl.idle(2'h0);
    apb(1'b1, 8'h00, 32'h0000_0022);
    exp_mem[0] = 16'ha011;
    exp_mem[4] = 16'h6666;
    for (int c = 0; c < 4; c++) exp_mem[12 + c] = 16'h1111 * 16'(c + 2);
    rd_check(8'h00, 4, 2, 1'b0);
    rd_check(8'h0c, 4, 2, 1'b0);
    rd_check(8'h04, 4, 2, 1'b0);
    // A second read one clock later takes over after the latency.
    ctl.step(RD, 12'h000, 2'h0, 16'h0000);
    ctl.step(RD, 12'h008, 2'h0, 16'h0000);
    ctl.idle(2'h0);
    `CHK(dq_o, exp_mem[0], "old word")
    ctl.idle(2'h0);
    `CHK(dq_o, exp_mem[8], "new word")
    repeat (5) ctl.idle(2'h0);
    // Precharge cuts a latency-three read short.
    apb(1'b1, 8'h00, 32'h0000_0033);
    ctl.step(RD, 12'h000, 2'h0, 16'h0000);
    ctl.idle(2'h0);
    ctl.step(PR, 12'h000, 2'h0, 16'h0000);
    ctl.idle(2'h0);
    ctl.idle(2'h0);
    `CHK(dq_oe, 2'h3, "last word")
    ctl.idle(2'h0);
    `CHK(dq_oe, 2'h0, "ended by precharge")
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd[3:0], 4'h0, "bank 0 idle")
    ctl.step(RD, 12'h000, 2'h0, 16'h0000);
    repeat (4) begin
      ctl.idle(2'h0);
      `CHK(dq_oe, 2'h0, "read of idle bank")
    end
    // Bank select on activate and precharge of both banks.
    ctl.step(AC, 12'h800, 2'h0, 16'h0000);
    ctl.idle(2'h0);
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd[3:0], 4'h2, "bank 1 open")
    ctl.step(AC, 12'h000, 2'h0, 16'h0000);
    ctl.step(PR, 12'h400, 2'h0, 16'h0000);
    ctl.idle(2'h0);
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd[3:0], 4'h0, "all banks closed")
    // Read with auto-precharge leaves the bank closed.
    apb(1'b1, 8'h00, 32'h0000_0022);
    ctl.step(AC, 12'h000, 2'h0, 16'h0000);
    ctl.step(RD, 12'h400, 2'h0, 16'h0000);
    repeat (6) ctl.idle(2'h0);
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd[0], 1'b0, "auto precharge")
    // Full page ignores auto-precharge and runs until burst stop.
    apb(1'b1, 8'h00, 32'h0000_0027);
    ctl.step(AC, 12'h000, 2'h0, 16'h0000);
    ctl.step(RD, 12'h400, 2'h0, 16'h0000);
    ctl.idle(2'h0);
    apb(1'b0, 8'h04, 32'h0);
    `CHK({dq_oe, rd[4], rd[0]}, 4'hf, "full page runs")
    ctl.step(BS, 12'h000, 2'h0, 16'h0000);
    ctl.idle(2'h0);
    `CHK(dq_oe, 2'h3, "word before stop")
    ctl.idle(2'h0);
    `CHK(dq_oe, 2'h0, "stopped")
    // A precharge while the enable is low must leave bank 0 open.
    ce <= 1'b0;
    ctl.step(PR, 12'h400, 2'h0, 16'h0000);
    ce <= 1'b1;
    ctl.idle(2'h0);
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd[3:0], 4'h1, "enable low froze banks")
    // A reset in mid-run closes the banks and restores the mode.
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK({pready, pslverr, dq_oe}, 4'h0, "outputs after second reset")
    apb(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h0000_0022, "mode after second reset")
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd[3:0], 4'h0, "banks after second reset")
    give_verdict();
  end
endmodule // test_sdram_burst_bank_control
